// [spifc_ctrl.sv]
/*
  Control core of the serial-link unit: slave-select output, single-wire
  mode, mode-fault handling, flags and low-power behaviour.
  Assumes register accesses arrive as one-cycle strobes on i_ref_clk and
  that the link pins come from outside and are resynchronised here.
*/
`timescale 1ns/1ps

// Function
// - Drive select low in transfer, high idle
// - Select output only controller, both enables
// - No fault detection while select output on
// - Single-wire select picks shared data pin
// - Shared pin direction from its output enable
// - SCK out as controller, in as target
// - Fault in single-wire controller moves to MISO
// - Controller with detect enable faults on low
// - Detect disabled controller ignores select pin
// - Target never raises a mode fault
// - Fault drops controller, aborts, releases pins
// - Fault in single-wire mode clears shared pin output enable
// - Status read then control write clears fault
// - Pending byte stays queued on mode fault
// - Block disabled freezes core, registers stay
// - Halt in wait stops clock generation
// - Controller transfer pauses and resumes over wait
// - Target keeps shifting on external clock in wait
// - Target defers flag and copy, drops pending
// - Copy on exit only if wait touched transfer
// - Stop freezes controller, independent of halt bit
// - Data register reads zero after reset
// - Interrupt is OR of three flags when enabled
// - Set receive full and transmit empty flags
// - Receive full half SCK after last edge
module spifc_ctrl
  import spifc_pkg::*;
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // Register access strobes
  input  wire spifc_ctrl1_t i_ctrl1,
  input  wire logic         i_ctrl1_wr,
  input  wire spifc_ctrl2_t i_ctrl2,
  input  wire logic         i_ctrl2_wr,
  input  wire logic         i_status_rd,
  input  wire logic         i_data_rd,
  input  wire logic         i_data_wr,
  input  wire logic [7:0]   i_data,
  // Processor power state
  input  wire logic         i_wait,
  input  wire logic         i_stop,
  // Link pins in
  input  wire logic         i_sck,
  input  wire logic         i_mosi,
  input  wire logic         i_miso,
  input  wire logic         i_ss,
  // Link pins out
  output spifc_pins_t       o_pins,
  // Register readback
  output logic [7:0]        o_data_reg,
  output spifc_stat_t       o_status,
  output spifc_ctrl1_t      o_ctrl1,
  output spifc_ctrl2_t      o_ctrl2,
  output logic              o_irq
);

  // ==========================================================
  // State
  spifc_state_t s;
  spifc_state_t nx;
  logic         halted;
  logic         en;
  logic         ctl;
  logic         din;
  logic         rise;
  logic         fall;
  logic         fault;

  // ==========================================================
  // Next state
  always_comb begin
    nx = s;
    // Stop mode halts regardless of the halt-in-wait bit
    halted = (i_wait & s.c2.halt_in_wait) | i_stop;
    en = s.c1.block_enable;
    ctl = s.c1.controller_select;
    din = (ctl ^ s.c2.single_wire_select) ? s.s2.miso : s.s2.mosi;
    rise = 1'b0;
    fall = 1'b0;
    fault = en & ctl & s.c1.fault_detect_enable
          & ~s.c1.ss_drive_enable & ~s.s2.ss;

    // Only the second stage of each synchroniser is read
    nx.s1 = {i_sck, i_mosi, i_miso, i_ss};
    nx.s2 = s.s1;
    nx.sck_prev = s.s2.sck;
    nx.ss_prev = s.s2.ss;
    nx.halted_prev = halted;

    // Register side stays live even while disabled
    if (i_status_rd) begin
      nx.seen = s.flags;
    end
    if (i_ctrl2_wr) begin
      nx.c2 = i_ctrl2;
    end
    if (i_ctrl1_wr) begin
      nx.c1 = i_ctrl1;
      if (s.seen.mode_fault_flag) begin
        nx.flags.mode_fault_flag = 1'b0;
        nx.seen.mode_fault_flag = 1'b0;
      end
    end
    if (i_data_rd && s.seen.rx_full_flag) begin
      nx.flags.rx_full_flag = 1'b0;
      nx.seen.rx_full_flag = 1'b0;
    end
    if (i_data_wr) begin
      nx.tx_buf = i_data;
      nx.tx_pend = 1'b1;
      if (s.seen.tx_empty_flag) begin
        nx.flags.tx_empty_flag = 1'b0;
        nx.seen.tx_empty_flag = 1'b0;
      end
    end

    // Core runs only when enabled
    if (en) begin
      // Target wait entry and exit bookkeeping
      if (!ctl && halted && !s.halted_prev) begin
        if (s.ph == SPIFC_FINISH) begin
          nx.ph = SPIFC_IDLE;
        end
        if (s.ph == SPIFC_SHIFT) begin
          nx.wait_xfer = 1'b1;
        end
      end
      if (!ctl && !halted && s.halted_prev && s.ph != SPIFC_IDLE) begin
        nx.wait_xfer = 1'b1;
      end
      if (!ctl && !halted && s.wait_xfer && s.ph == SPIFC_IDLE) begin
        nx.data_reg = s.shifter;
        nx.flags.rx_full_flag = 1'b1;
        nx.wait_xfer = 1'b0;
      end

      unique case (s.ph)
        SPIFC_IDLE: begin
          if ((ctl && s.tx_pend && !halted && !s.flags.mode_fault_flag)
              || (!ctl && !s.s2.ss && s.ss_prev)) begin
            // Target loads the transmit buffer on every select fall; with no new
            // write it sends the last byte written again
            nx.shifter = s.tx_buf;
            nx.out_hold = s.tx_buf[7];
            nx.bits = '0;
            nx.div = SPIFC_HALF_CLKS - 4'h1;
            nx.sck_lvl = 1'b0;
            nx.ph = SPIFC_SHIFT;
            if (s.tx_pend) begin
              // A byte written in this very cycle must stay queued
              nx.tx_pend = i_data_wr;
              nx.flags.tx_empty_flag = 1'b1;
            end
          end
        end
        SPIFC_SHIFT: begin
          if (!ctl && s.s2.ss) begin
            nx.ph = SPIFC_IDLE;
          end else if (!(ctl && halted)) begin
            if (ctl) begin
              if (s.div == 4'h0) begin
                nx.div = SPIFC_HALF_CLKS - 4'h1;
                nx.sck_lvl = ~s.sck_lvl;
                rise = ~s.sck_lvl;
                fall = s.sck_lvl;
              end else begin
                nx.div = s.div - 4'h1;
              end
            end else begin
              // Target follows the outside clock even in wait
              rise = s.s2.sck & ~s.sck_prev;
              fall = ~s.s2.sck & s.sck_prev;
            end
            if (rise) begin
              nx.shifter = {s.shifter[6:0], din};
              nx.bits = s.bits + 4'h1;
            end
            if (fall) begin
              if (s.bits == SPIFC_XFER_BITS) begin
                nx.ph = SPIFC_FINISH;
                nx.div = SPIFC_HALF_CLKS - 4'h1;
              end else begin
                nx.out_hold = s.shifter[7];
              end
            end
          end
        end
        SPIFC_FINISH: begin
          if (!(ctl && halted)) begin
            if (s.div == 4'h0) begin
              nx.ph = SPIFC_IDLE;
              if (!ctl && halted) begin
                nx.wait_xfer = 1'b1;
              end else begin
                nx.data_reg = s.shifter;
                nx.flags.rx_full_flag = 1'b1;
                nx.wait_xfer = 1'b0;
              end
            end else begin
              nx.div = s.div - 4'h1;
            end
          end
        end
      endcase
    end

    // Fault wins over any software write in the same cycle
    if (fault) begin
      nx.flags.mode_fault_flag = 1'b1;
      nx.c1.controller_select = 1'b0;
      nx.ph = SPIFC_IDLE;
      nx.sck_lvl = 1'b0;
      nx.wait_xfer = 1'b0;
      if (s.c2.single_wire_select) begin
        nx.c2.shared_pin_output_enable = 1'b0;
      end
    end

    // Pin drive follows the next state so pins come from flops
    nx.pins.sck = nx.sck_lvl;
    nx.pins.sck_oe = nx.c1.block_enable & nx.c1.controller_select;
    nx.pins.ss = (nx.ph == SPIFC_IDLE);
    nx.pins.ss_oe = nx.c1.block_enable & nx.c1.controller_select
                  & nx.c1.ss_drive_enable & nx.c1.fault_detect_enable;
    nx.pins.mosi = nx.out_hold;
    nx.pins.miso = nx.out_hold;
    nx.pins.mosi_oe = nx.c1.block_enable & nx.c1.controller_select
                    & (~nx.c2.single_wire_select
                       | nx.c2.shared_pin_output_enable);
    // Target buffer stays off while a fault is flagged
    nx.pins.miso_oe = nx.c1.block_enable & ~nx.c1.controller_select
                    // Second sync stage only: the first may be metastable
                    & ~s.s2.ss & ~nx.flags.mode_fault_flag
                    & (~nx.c2.single_wire_select
                       | nx.c2.shared_pin_output_enable);
    nx.irq = nx.c1.block_enable & (|nx.flags);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s <= SPIFC_RST;
    end else begin
      s <= nx;
    end
  end

  // ==========================================================
  // Outputs
  assign o_pins = s.pins;
  assign o_data_reg = s.data_reg;
  assign o_status = s.flags;
  assign o_ctrl1 = s.c1;
  assign o_ctrl2 = s.c2;
  assign o_irq = s.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ss_level;
    s.pins.ss_oe |-> (s.pins.ss == (s.ph == SPIFC_IDLE))
      && (!$changed(s.pins.sck) || !s.pins.ss);
  endproperty
  a_ss_level: assert property (p_ss_level)
    else $error("select level does not follow transfer");

  property p_ss_oe_cond;
    s.pins.ss_oe |-> (s.c1.controller_select && s.c1.ss_drive_enable
                      && s.c1.fault_detect_enable);
  endproperty
  a_ss_oe_cond: assert property (p_ss_oe_cond)
    else $error("select driven without its enables");

  property p_ssout_no_fault;
    (s.c1.ss_drive_enable && !s.flags.mode_fault_flag)
      |=> !s.flags.mode_fault_flag;
  endproperty
  a_ssout_no_fault: assert property (p_ssout_no_fault)
    else $error("fault raised with select output on");

  property p_fault_set;
    (s.c1.block_enable && s.c1.controller_select
     && s.c1.fault_detect_enable && !s.c1.ss_drive_enable && !s.s2.ss)
      |=> (s.flags.mode_fault_flag && !s.c1.controller_select
           && s.ph == SPIFC_IDLE);
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("low select did not raise fault");

  property p_fault_noen;
    (!s.c1.fault_detect_enable && !s.flags.mode_fault_flag)
      |=> !s.flags.mode_fault_flag;
  endproperty
  a_fault_noen: assert property (p_fault_noen)
    else $error("fault raised with detection off");

  property p_target_nofault;
    (!s.c1.controller_select && !s.flags.mode_fault_flag)
      |=> !s.flags.mode_fault_flag;
  endproperty
  a_target_nofault: assert property (p_target_nofault)
    else $error("fault raised in target mode");

  property p_fault_release;
    s.flags.mode_fault_flag |-> !(s.pins.sck_oe || s.pins.miso_oe
      || s.pins.ss_oe || (s.pins.mosi_oe && !s.c1.controller_select));
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("pin still driven during fault");

  property p_fault_shared;
    (!s.c1.ss_drive_enable && s.c1.block_enable
     && s.c1.controller_select && s.c1.fault_detect_enable
     && s.c2.single_wire_select && !s.s2.ss)
      |=> !s.c2.shared_pin_output_enable;
  endproperty
  a_fault_shared: assert property (p_fault_shared)
    else $error("shared output enable kept after fault");

  property p_mode_fault_flag_clear;
    (s.seen.mode_fault_flag && i_ctrl1_wr && !fault && !i_status_rd)
      |=> !s.flags.mode_fault_flag;
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear)
    else $error("fault flag not cleared by access pair");

  property p_halt_freeze;
    (halted && s.c1.controller_select && !fault && s.c1.block_enable)
      |=> $stable(s.shifter) && $stable(s.bits);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("controller shifted while halted");

  property p_rx_half;
    (s.ph == SPIFC_SHIFT && !fault && !halted && s.c1.block_enable
     && s.c1.controller_select ##1 s.ph == SPIFC_FINISH
     && $past(s.ph) == SPIFC_SHIFT)
      |-> (s.ph == SPIFC_FINISH && !s.flags.mode_fault_flag)[*4]
          ##1 (s.flags.rx_full_flag || s.flags.mode_fault_flag || halted);
  endproperty
  a_rx_half: assert property (p_rx_half)
    else $error("receive full not half period after last edge");

  property p_irq;
    s.irq == (s.c1.block_enable && (|s.flags));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised with flag set");

  c_ctrl_done: cover property (s.ph == SPIFC_FINISH
    && s.c1.controller_select ##[1:8] s.flags.rx_full_flag);
  c_fault: cover property ($rose(s.flags.mode_fault_flag));
  c_target: cover property (!s.c1.controller_select
    && s.ph == SPIFC_SHIFT ##[1:300] s.ph == SPIFC_FINISH);
  c_wait_copy: cover property (s.wait_xfer && !halted
    ##1 s.flags.rx_full_flag);
  c_shared_fault: cover property (s.c2.single_wire_select
    && $rose(s.flags.mode_fault_flag));

endmodule

// [spifc_ctrl_tb.sv]
/*
  Self-checking bench for the serial-link control block.
  Assumes the partner model in its own file and strobes driven
  at the falling clock edge.
*/
`timescale 1ns/1ps

module spifc_ctrl_tb;
  import spifc_pkg::*;
  logic         i_ref_clk, i_rst_n, i_wait, i_stop;
  logic         i_ctrl1_wr, i_ctrl2_wr, i_status_rd, i_data_rd, i_data_wr;
  spifc_ctrl1_t i_ctrl1, o_ctrl1;
  spifc_ctrl2_t i_ctrl2, o_ctrl2;
  logic [7:0]   i_data, o_data_reg, p_tx, p_rx;
  spifc_pins_t  o_pins;
  spifc_stat_t  o_status;
  logic         o_irq, p_sck, p_mosi, p_miso, p_ss, ss_lo, as_ctrl;
  wire logic    w_sck, w_mosi, w_miso, w_ss;
  int           miscompares = 0;
  int           n_compared = 0;

  // ==========================================================
  // Wire resolution
  assign w_sck  = o_pins.sck_oe ? o_pins.sck : p_sck;
  assign w_mosi = o_pins.mosi_oe ? o_pins.mosi : p_mosi;
  assign w_miso = o_pins.miso_oe ? o_pins.miso : p_miso;
  assign w_ss   = o_pins.ss_oe ? o_pins.ss : (p_ss & ~ss_lo);

  spifc_ctrl spifc_ctrl_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_ctrl1(i_ctrl1), .i_ctrl1_wr(i_ctrl1_wr), .i_ctrl2(i_ctrl2),
    .i_ctrl2_wr(i_ctrl2_wr), .i_status_rd(i_status_rd),
    .i_data_rd(i_data_rd), .i_data_wr(i_data_wr), .i_data(i_data),
    .i_wait(i_wait), .i_stop(i_stop), .i_sck(w_sck), .i_mosi(w_mosi),
    .i_miso(w_miso), .i_ss(w_ss), .o_pins(o_pins),
    .o_data_reg(o_data_reg), .o_status(o_status), .o_ctrl1(o_ctrl1),
    .o_ctrl2(o_ctrl2), .o_irq(o_irq));

  spifc_partner spifc_partner_inst (.i_sck(w_sck), .i_mosi(w_mosi),
    .i_miso(w_miso), .i_ss(w_ss), .i_as_ctrl(as_ctrl), .i_tx(p_tx),
    .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso), .o_ss(p_ss),
    .o_rx(p_rx));

  initial i_ref_clk = 1'b0;
  always #50 i_ref_clk = ~i_ref_clk;

  // ==========================================================
  // Helpers
  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic wr1(logic [3:0] v);
    i_ctrl1 = spifc_ctrl1_t'(v);
    i_ctrl1_wr = 1'b1;
    cyc(1);
    i_ctrl1_wr = 1'b0;
  endtask
  task automatic wr2(logic [2:0] v);
    i_ctrl2 = spifc_ctrl2_t'(v);
    i_ctrl2_wr = 1'b1;
    cyc(1);
    i_ctrl2_wr = 1'b0;
  endtask
  task automatic wrd(logic [7:0] v);
    i_data = v;
    i_data_wr = 1'b1;
    cyc(1);
    i_data_wr = 1'b0;
  endtask
  // Status read then data read: empties the receive side
  task automatic clr_rx();
    i_status_rd = 1'b1;
    cyc(1);
    i_status_rd = 1'b0;
    i_data_rd = 1'b1;
    cyc(1);
    i_data_rd = 1'b0;
    cyc(1);
  endtask
  task automatic wait_rx(output int k);
    k = 0;
    while (o_status.rx_full_flag !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_ctrl_xfer();
    int k;
    wr1(4'he);
    cyc(2);
    chk1("ss_oe_nofd", 1'b0, o_pins.ss_oe);
    wr1(4'hf);
    p_tx = 8'h3c;
    cyc(2);
    chk1("sck_oe", 1'b1, o_pins.sck_oe);
    i_status_rd = 1'b1;
    cyc(1);
    i_status_rd = 1'b0;
    wrd(8'ha5);
    chk1("tx_taken", 1'b0, o_status.tx_empty_flag);
    cyc(10);
    chk1("tx_free", 1'b1, o_status.tx_empty_flag);
    chk1("ss_busy", 1'b0, o_pins.ss);
    chk1("ss_oe", 1'b1, o_pins.ss_oe);
    chk1("fault_own_ss", 1'b0, o_status.mode_fault_flag);
    wait_rx(k);
    chk8("rx_latency", 8'(1 + (2 * SPIFC_XFER_BITS + 1) * SPIFC_HALF_CLKS),
      8'(k + 10));
    chk8("data_reg", 8'h3c, o_data_reg);
    chk8("far_rx", 8'ha5, p_rx);
    chk1("ss_idle", 1'b1, o_pins.ss);
    chk1("irq", 1'b1, o_irq);
    clr_rx();
    chk1("rx_cleared", 1'b0, o_status.rx_full_flag);
  endtask

  task automatic t_fault();
    wr2(3'b101);
    wr1(4'hd);
    wrd(8'h11);
    cyc(20);
    chk1("miso_free", 1'b0, o_pins.miso_oe);
    ss_lo = 1'b1;
    cyc(4);
    chk1("fault", 1'b1, o_status.mode_fault_flag);
    chk1("ctrl_sel", 1'b0, o_ctrl1.controller_select);
    chk8("oes", 8'h00, 8'(o_pins & 8'h55));
    chk1("shared_oe", 1'b0, o_ctrl2.shared_pin_output_enable);
    chk1("irq_fault", 1'b1, o_irq);
    ss_lo = 1'b0;
    cyc(80);
    chk1("rx_lost", 1'b0, o_status.rx_full_flag);
    chk8("data_kept", 8'h3c, o_data_reg);
    i_status_rd = 1'b1;
    cyc(1);
    i_status_rd = 1'b0;
    wr1(4'hd);
    cyc(1);
    chk1("fault_clr", 1'b0, o_status.mode_fault_flag);
    wr2(3'b000);
    wr1(4'hc);
    ss_lo = 1'b1;
    cyc(6);
    chk1("fault_off", 1'b0, o_status.mode_fault_flag);
    chk1("sel_kept", 1'b1, o_ctrl1.controller_select);
    ss_lo = 1'b0;
    cyc(80);
    clr_rx();
  endtask

  task automatic t_target(logic in_wait);
    wr1(4'h8);
    wr2({1'b0, in_wait, 1'b0});
    wrd(8'h5a);
    cyc(2);
    chk1("sck_in", 1'b0, o_pins.sck_oe);
    p_tx = in_wait ? 8'h44 : 8'h96;
    as_ctrl = 1'b1;
    fork
      spifc_partner_inst.frame();
      begin
        cyc(20);
        i_wait = in_wait;
        chk1("tgt_fault", 1'b0, o_status.mode_fault_flag);
      end
    join
    cyc(6);
    chk1("rx_held", !in_wait, o_status.rx_full_flag);
    i_wait = 1'b0;
    cyc(10);
    chk1("rx_exit", 1'b1, o_status.rx_full_flag);
    chk8("tgt_data", p_tx, o_data_reg);
    chk8("tgt_sent", 8'h5a, p_rx);
    as_ctrl = 1'b0;
    clr_rx();
    i_wait = 1'b1;
    cyc(10);
    i_wait = 1'b0;
    cyc(10);
    chk1("idle_wait", 1'b0, o_status.rx_full_flag);
  endtask

  // Halt through wait with the halt bit set, or through stop without it
  task automatic t_halt(logic by_stop);
    int k;
    int chg;
    logic s;
    logic [7:0] tx;
    tx = by_stop ? 8'h2d : 8'h69;
    wr1(4'hf);
    wr2({1'b0, !by_stop, 1'b0});
    p_tx = by_stop ? 8'hb4 : 8'hc3;
    wrd(tx);
    cyc(30);
    i_stop = by_stop;
    i_wait = !by_stop;
    cyc(2);
    s = o_pins.sck;
    chg = 0;
    repeat (40) begin
      cyc(1);
      if (o_pins.sck !== s) chg++;
    end
    chk8("sck_frozen", 8'h00, 8'(chg));
    chk1("ss_held", 1'b0, o_pins.ss);
    i_stop = 1'b0;
    i_wait = 1'b0;
    wait_rx(k);
    chk1("resumed_done", 1'b1, o_status.rx_full_flag);
    chk8("resumed_rx", p_tx, o_data_reg);
    chk8("resumed_tx", tx, p_rx);
    clr_rx();
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    i_rst_n = 1'b0;
    {i_wait, i_stop, ss_lo, as_ctrl} = 4'h0;
    {i_ctrl1_wr, i_ctrl2_wr, i_status_rd, i_data_rd, i_data_wr} = 5'h00;
    i_ctrl1 = spifc_ctrl1_t'(4'h0);
    i_ctrl2 = spifc_ctrl2_t'(3'h0);
    i_data = 8'h00;
    p_tx = 8'h00;
    cyc(6);
    i_rst_n = 1'b1;
    cyc(3);
    chk8("data_rst", 8'h00, o_data_reg);
    chk1("irq_off", 1'b0, o_irq);
    t_ctrl_xfer();
    t_fault();
    t_target(1'b0);
    t_target(1'b1);
    t_halt(1'b0);
    t_halt(1'b1);
    print_verdict();
  end

  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule

// [spifc_partner.sv]
/*
  Far-side device model for the serial-link control block.
  Assumes resolved wire levels are fed in and its outputs are
  only put on a wire while the block leaves that wire undriven.
*/
`timescale 1ns/1ps

module spifc_partner
  import spifc_pkg::*;
(
  // Wires
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  input  wire logic       i_ss,
  // Role and data
  input  wire logic       i_as_ctrl,
  input  wire logic [7:0] i_tx,
  // Driven levels
  output logic            o_sck,
  output logic            o_mosi,
  output logic            o_miso,
  output logic            o_ss,
  output logic [7:0]      o_rx
);
  logic [7:0] sh;

  initial begin
    o_sck  = 1'b0;
    o_mosi = 1'b0;
    o_miso = 1'b0;
    o_ss   = 1'b1;
    o_rx   = 8'h00;
    sh     = 8'h00;
  end

  // ==========================================================
  // Target role: mode 0, MSB first
  always @(negedge i_ss) if (!i_as_ctrl) begin
    sh = i_tx;
    o_miso = sh[7];
  end
  always @(posedge i_sck) if (!i_as_ctrl) o_rx = {o_rx[6:0], i_mosi};
  always @(negedge i_sck) if (!i_as_ctrl && !i_ss) begin
    sh = sh << 1;
    o_miso = sh[7];
  end
  // No pull on the line: show the inverse once deselected
  always @(posedge i_ss) if (!i_as_ctrl) o_miso = ~o_miso;

  // ==========================================================
  // Controller role: 800 ns clock, only within the frame
  task automatic frame();
    int i;
    o_ss = 1'b0;
    for (i = 7; i >= 0; i--) begin
      o_mosi = i_tx[i];
      #400 o_sck = 1'b1;
      o_rx = {o_rx[6:0], i_miso};
      #400 o_sck = 1'b0;
    end
    #400 o_ss = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule

// [spifc_pkg.sv]
/*
  Shared types and constants of the serial-link control block.
  Assumes a 10 MHz module clock and an 8-bit shift width.
*/
package spifc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned SPIFC_CLK_NS      = 100;
  // Controller SCK half period, fixed here since baud is not covered
  localparam int unsigned SPIFC_SCK_HALF_NS = 400;
  localparam logic [3:0]  SPIFC_HALF_CLKS   =
    4'(SPIFC_SCK_HALF_NS / SPIFC_CLK_NS);
  localparam logic [3:0]  SPIFC_XFER_BITS   = 4'h8;
  localparam logic [7:0]  SPIFC_DATA_RST    = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SPIFC_IDLE   = 3'b001,
    SPIFC_SHIFT  = 3'b010,
    SPIFC_FINISH = 3'b100
  } spifc_phase_t;

  typedef struct packed {
    logic block_enable;
    logic controller_select;
    logic ss_drive_enable;
    logic fault_detect_enable;
  } spifc_ctrl1_t;

  typedef struct packed {
    logic single_wire_select;
    logic halt_in_wait;
    logic shared_pin_output_enable;
  } spifc_ctrl2_t;

  typedef struct packed {
    logic mode_fault_flag;
    logic rx_full_flag;
    logic tx_empty_flag;
  } spifc_stat_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss;
    logic ss_oe;
  } spifc_pins_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spifc_sync_t;

  typedef struct packed {
    spifc_ctrl1_t c1;
    spifc_ctrl2_t c2;
    spifc_stat_t  flags;
    spifc_stat_t  seen;
    logic [7:0]   data_reg;
    logic [7:0]   tx_buf;
    logic         tx_pend;
    logic [7:0]   shifter;
    logic         out_hold;
    logic [3:0]   bits;
    logic [3:0]   div;
    logic         sck_lvl;
    spifc_phase_t ph;
    spifc_sync_t  s1;
    spifc_sync_t  s2;
    logic         sck_prev;
    logic         ss_prev;
    logic         halted_prev;
    logic         wait_xfer;
    spifc_pins_t  pins;
    logic         irq;
  } spifc_state_t;

  function automatic spifc_state_t spifc_rst_f();
    spifc_state_t r;
    r = '0;
    r.flags.tx_empty_flag = 1'b1;
    r.data_reg = SPIFC_DATA_RST;
    r.ph = SPIFC_IDLE;
    r.s1.ss = 1'b1;
    r.s2.ss = 1'b1;
    r.ss_prev = 1'b1;
    r.pins.ss = 1'b1;
    return r;
  endfunction

  localparam spifc_state_t SPIFC_RST = spifc_rst_f();

endpackage
